/* File: hw/gars_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gars_regs.svh"
module gars_top (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CORE_CE,
  input wire gars_pkg::gars_addr_t I_REG_ADDR,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire gars_pkg::gars_word_t I_REG_WDATA,
  output gars_pkg::gars_word_t O_REG_RDATA,
  output logic O_REG_RVALID,
  output logic O_REG_HIT,
  input wire logic I_PAGE_VALID,
  input wire gars_pkg::gars_word_t I_PAGE_WORD,
  input wire logic I_MS_FAULT,
  input wire logic I_MS_AUTO_MASTER,
  input wire logic I_LOCAL_RX_OK,
  input wire logic I_REMOTE_RX_OK,
  input wire logic I_PARTNER_1G_FD,
  input wire logic I_PARTNER_1G_HD,
  input wire logic I_IDLE_ERR,
  input wire logic I_LINK_UP,
  output gars_pkg::gars_test_mode_t O_TEST_MODE,
  output logic O_TEST_ACTIVE,
  output logic O_MS_MANUAL_EN,
  output logic O_MS_MANUAL_MASTER,
  output logic O_ROLE_MASTER,
  output logic O_ADV_MULTI_PORT,
  output logic O_ADV_1G_FD,
  output logic O_ADV_1G_HD,
  output logic O_AUTO_CT_EN,
  output logic O_CABLE_TEST_START
);
  import gars_pkg::*;

  localparam gars_word_t CTRL_RST = `GARS_CTRL_RESET;

  logic more_pages_wanted_reg;
  logic partner_ack_reg;
  logic message_page_flag_reg;
  logic second_acknowledge_reg;
  logic page_toggle_reg;
  gars_code_t page_code_reg;
  logic fault_reg;
  logic [`GARS_IDLE_W-1:0] idle_count;
  gars_link_t link_reg;
  gars_link_t link_next;
  logic wr_page;
  logic wr_ctrl;
  logic rd_stat;
  logic hit;
  gars_word_t page_word;
  gars_word_t ctrl_word;
  gars_word_t stat_word;
  gars_word_t rdata_next;

  // address decode; only direct addresses reach this bank
  always_comb begin
    wr_page = 1'b0;
    wr_ctrl = 1'b0;
    rd_stat = 1'b0;
    hit = 1'b0;
    if (I_REG_ADDR > `GARS_ADDR_DIRECT_MAX) begin
      hit = 1'b0;
    end else if (I_REG_ADDR == `GARS_ADDR_PAGE) begin
      hit = 1'b1;
      wr_page = I_REG_WR;
    end else if (I_REG_ADDR == `GARS_ADDR_CTRL) begin
      hit = 1'b1;
      wr_ctrl = I_REG_WR;
    end else if (I_REG_ADDR == `GARS_ADDR_STAT) begin
      hit = 1'b1;
      rd_stat = I_REG_RD;
    end
  end

  // received next page; a page arriving beats a software write
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      more_pages_wanted_reg <= 1'b0;
      partner_ack_reg <= 1'b0;
      message_page_flag_reg <= 1'b1;
      second_acknowledge_reg <= 1'b0;
      page_toggle_reg <= 1'b0;
      page_code_reg <= `GARS_CODE_NULL;
    end else if (I_CORE_CE) begin
      if (I_PAGE_VALID) begin
        more_pages_wanted_reg <= I_PAGE_WORD[`GARS_PG_MORE];
        partner_ack_reg <= I_PAGE_WORD[`GARS_PG_ACK];
        message_page_flag_reg <= I_PAGE_WORD[`GARS_PG_MSG];
        second_acknowledge_reg <= I_PAGE_WORD[`GARS_PG_SECOND_ACKNOWLEDGE];
        page_toggle_reg <= !I_PAGE_WORD[`GARS_PG_TOG];
        page_code_reg <= I_PAGE_WORD[10:0];
      end else if (wr_page) begin
        // ack and toggle are read-only, the rest accept writes
        more_pages_wanted_reg <= I_REG_WDATA[`GARS_PG_MORE];
        message_page_flag_reg <= I_REG_WDATA[`GARS_PG_MSG];
        second_acknowledge_reg <= I_REG_WDATA[`GARS_PG_SECOND_ACKNOWLEDGE];
        page_code_reg <= I_REG_WDATA[10:0];
      end
    end
  end

  // gigabit control; outputs are the register bits themselves
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      O_TEST_MODE <= CTRL_RST[`GARS_CT_TEST_HI:`GARS_CT_TEST_LO];
      O_MS_MANUAL_EN <= CTRL_RST[`GARS_CT_MAN_EN];
      O_MS_MANUAL_MASTER <= CTRL_RST[`GARS_CT_MAN_VAL];
      O_ADV_MULTI_PORT <= CTRL_RST[`GARS_CT_PORT];
      O_ADV_1G_FD <= CTRL_RST[`GARS_CT_ADV_FD];
      O_ADV_1G_HD <= CTRL_RST[`GARS_CT_ADV_HD];
      O_AUTO_CT_EN <= CTRL_RST[`GARS_CT_AUTO_CT];
    end else if (I_CORE_CE && wr_ctrl) begin
      // bits 6:0 have no storage, so writes to them vanish
      O_TEST_MODE <=
        I_REG_WDATA[`GARS_CT_TEST_HI:`GARS_CT_TEST_LO];
      O_MS_MANUAL_EN <= I_REG_WDATA[`GARS_CT_MAN_EN];
      O_MS_MANUAL_MASTER <= I_REG_WDATA[`GARS_CT_MAN_VAL];
      O_ADV_MULTI_PORT <= I_REG_WDATA[`GARS_CT_PORT];
      O_ADV_1G_FD <= I_REG_WDATA[`GARS_CT_ADV_FD];
      O_ADV_1G_HD <= I_REG_WDATA[`GARS_CT_ADV_HD];
      O_AUTO_CT_EN <= I_REG_WDATA[`GARS_CT_AUTO_CT];
    end
  end

  // test pattern generator enable follows the mode field
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      O_TEST_ACTIVE <= 1'b0;
    end else if (I_CORE_CE) begin
      O_TEST_ACTIVE <= (O_TEST_MODE != `GARS_TEST_NORMAL);
    end
  end

  // role: manual value wins only with manual enable set
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      O_ROLE_MASTER <= 1'b0;
    end else if (I_CORE_CE) begin
      if (O_MS_MANUAL_EN) begin
        O_ROLE_MASTER <= O_MS_MANUAL_MASTER;
      end else begin
        O_ROLE_MASTER <= I_MS_AUTO_MASTER;
      end
    end
  end

  // latched fault; a fault in the read cycle survives the clear
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      fault_reg <= 1'b0;
    end else if (I_CORE_CE) begin
      if (I_MS_FAULT) begin
        fault_reg <= 1'b1;
      end else if (rd_stat) begin
        fault_reg <= 1'b0;
      end
    end
  end

  gars_sat_cnt #(
    .W(`GARS_IDLE_W)
  ) u_idle_cnt (
    .i_clk(I_CORE_CLK),
    .i_reset_n(I_RESET_N),
    .i_ce(I_CORE_CE),
    .i_inc(I_IDLE_ERR),
    .i_clr(rd_stat),
    .o_count(idle_count)
  );

  // link drop watcher; a cable test only follows a link seen up
  always_comb begin
    link_next = link_reg;
    case (link_reg)
      GARS_LINK_DOWN: begin
        if (I_LINK_UP) begin
          link_next = GARS_LINK_SEEN;
        end
      end
      GARS_LINK_SEEN: begin
        if (!I_LINK_UP) begin
          link_next = GARS_LINK_DOWN;
        end
      end
      default: begin
        link_next = GARS_LINK_DOWN;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      link_reg <= GARS_LINK_DOWN;
      O_CABLE_TEST_START <= 1'b0;
    end else if (I_CORE_CE) begin
      link_reg <= link_next;
      O_CABLE_TEST_START <= O_AUTO_CT_EN && link_reg == GARS_LINK_SEEN
        && !I_LINK_UP;
    end
  end

  // read views
  always_comb begin
    page_word = {more_pages_wanted_reg, partner_ack_reg,
      message_page_flag_reg, second_acknowledge_reg, page_toggle_reg,
      page_code_reg};
    ctrl_word = '0;
    ctrl_word[`GARS_CT_TEST_HI:`GARS_CT_TEST_LO] = O_TEST_MODE;
    ctrl_word[`GARS_CT_MAN_EN] = O_MS_MANUAL_EN;
    ctrl_word[`GARS_CT_MAN_VAL] = O_MS_MANUAL_MASTER;
    ctrl_word[`GARS_CT_PORT] = O_ADV_MULTI_PORT;
    ctrl_word[`GARS_CT_ADV_FD] = O_ADV_1G_FD;
    ctrl_word[`GARS_CT_ADV_HD] = O_ADV_1G_HD;
    ctrl_word[`GARS_CT_AUTO_CT] = O_AUTO_CT_EN;
    stat_word = '0;
    stat_word[`GARS_ST_FAULT] = fault_reg;
    stat_word[`GARS_ST_ROLE] = O_ROLE_MASTER;
    stat_word[`GARS_ST_LOC_OK] = I_LOCAL_RX_OK;
    stat_word[`GARS_ST_REM_OK] = I_REMOTE_RX_OK;
    stat_word[`GARS_ST_LP_FD] = I_PARTNER_1G_FD;
    stat_word[`GARS_ST_LP_HD] = I_PARTNER_1G_HD;
    stat_word[7:0] = idle_count;
  end

  always_comb begin
    rdata_next = '0;
    if (I_REG_ADDR == `GARS_ADDR_PAGE) begin
      rdata_next = page_word;
    end else if (I_REG_ADDR == `GARS_ADDR_CTRL) begin
      rdata_next = ctrl_word;
    end else if (I_REG_ADDR == `GARS_ADDR_STAT) begin
      rdata_next = stat_word;
    end
  end

  // capture in the same edge that clears, so the old value is returned
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      O_REG_RDATA <= '0;
      O_REG_RVALID <= 1'b0;
      O_REG_HIT <= 1'b0;
    end else if (I_CORE_CE) begin
      O_REG_RVALID <= I_REG_RD;
      if (I_REG_RD) begin
        O_REG_RDATA <= rdata_next;
        O_REG_HIT <= hit;
      end
    end
  end

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RESET_N);

  fault_latch_a: assert property (
    (I_CORE_CE && I_MS_FAULT) |=> fault_reg [*1] ##1
      (fault_reg || $past(rd_stat && I_CORE_CE)))
    else $error("fault bit did not latch");

  fault_clear_a: assert property (
    (I_CORE_CE && rd_stat && !I_MS_FAULT) |=> !fault_reg)
    else $error("fault bit not cleared by status read");

  read_capture_a: assert property (
    (I_CORE_CE && rd_stat) |=>
      O_REG_RVALID && O_REG_RDATA[`GARS_ST_FAULT] == $past(fault_reg)
      && O_REG_RDATA[7:0] == $past(idle_count))
    else $error("status read lost its captured value");

  role_manual_a: assert property (
    (I_CORE_CE && O_MS_MANUAL_EN) |=>
      O_ROLE_MASTER == $past(O_MS_MANUAL_MASTER))
    else $error("manual role not applied");

  role_auto_a: assert property (
    (I_CORE_CE && !O_MS_MANUAL_EN) |=>
      O_ROLE_MASTER == $past(I_MS_AUTO_MASTER))
    else $error("automatic role not applied");

  ctrl_reserved_a: assert property (
    (I_CORE_CE && I_REG_RD && I_REG_ADDR == `GARS_ADDR_CTRL)
      |=> O_REG_RDATA[6:0] == 7'h00)
    else $error("control reserved bits read nonzero");

  stat_reserved_a: assert property (
    (I_CORE_CE && rd_stat) |=> O_REG_RDATA[9:8] == 2'h0)
    else $error("status reserved bits read nonzero");

  toggle_inverse_a: assert property (
    (I_CORE_CE && I_PAGE_VALID) |=>
      page_toggle_reg == !$past(I_PAGE_WORD[`GARS_PG_TOG]))
    else $error("toggle bit not inverted");

  cable_start_a: assert property (
    (I_CORE_CE && O_AUTO_CT_EN && link_reg == GARS_LINK_SEEN
      && !I_LINK_UP) |=> O_CABLE_TEST_START ##1 !O_CABLE_TEST_START
      || !$past(I_CORE_CE))
    else $error("cable test not started after link drop");

  cable_quiet_a: assert property (
    (I_CORE_CE && !O_AUTO_CT_EN) |=> !O_CABLE_TEST_START)
    else $error("cable test started while disabled");

  unmapped_zero_a: assert property (
    (I_CORE_CE && I_REG_RD && !hit) |=>
      O_REG_RDATA == 16'h0000 && !O_REG_HIT)
    else $error("unmapped address returned data");

  write_adv_a: assert property (
    (I_CORE_CE && wr_ctrl) |=>
      O_ADV_1G_FD == $past(I_REG_WDATA[`GARS_CT_ADV_FD])
      && O_ADV_1G_HD == $past(I_REG_WDATA[`GARS_CT_ADV_HD]))
    else $error("advertise bits not written");

  test_active_a: assert property (
    (I_CORE_CE && O_TEST_MODE == `GARS_TEST_NORMAL) |=> !O_TEST_ACTIVE)
    else $error("test pattern active in normal mode");

  page_capture_a: assert property (
    (I_CORE_CE && I_PAGE_VALID) |=>
      more_pages_wanted_reg == $past(I_PAGE_WORD[`GARS_PG_MORE])
      && partner_ack_reg == $past(I_PAGE_WORD[`GARS_PG_ACK])
      && second_acknowledge_reg == $past(I_PAGE_WORD[`GARS_PG_SECOND_ACKNOWLEDGE])
      && page_code_reg == $past(I_PAGE_WORD[10:0]))
    else $error("received page not captured");

  msg_flag_a: assert property (
    (I_CORE_CE && I_PAGE_VALID) |=>
      message_page_flag_reg == $past(I_PAGE_WORD[`GARS_PG_MSG]))
    else $error("message page flag not captured");

  port_type_a: assert property (
    (I_CORE_CE && wr_ctrl) |=>
      O_ADV_MULTI_PORT == $past(I_REG_WDATA[`GARS_CT_PORT]))
    else $error("port type bit not written");

  cable_no_up_a: assert property (
    (I_CORE_CE && link_reg == GARS_LINK_DOWN) |=> !O_CABLE_TEST_START)
    else $error("cable test started without a prior link");

  fault_wins_a: assert property (
    (I_CORE_CE && I_MS_FAULT && rd_stat) |=> fault_reg)
    else $error("fault lost in the read cycle");
endmodule : gars_top
`default_nettype wire

/* File: hw/gars_regs.svh */
`ifndef GARS_REGS_SVH
`define GARS_REGS_SVH
`define GARS_ADDR_PAGE 5'h08
`define GARS_ADDR_CTRL 5'h09
`define GARS_ADDR_STAT 5'h0a
`define GARS_ADDR_DIRECT_MAX 5'h1f
`define GARS_PG_MORE 15
`define GARS_PG_ACK 14
`define GARS_PG_MSG 13
`define GARS_PG_SECOND_ACKNOWLEDGE 12
`define GARS_PG_TOG 11
`define GARS_CT_TEST_HI 15
`define GARS_CT_TEST_LO 13
`define GARS_CT_MAN_EN 12
`define GARS_CT_MAN_VAL 11
`define GARS_CT_PORT 10
`define GARS_CT_ADV_FD 9
`define GARS_CT_ADV_HD 8
`define GARS_CT_AUTO_CT 7
`define GARS_ST_FAULT 15
`define GARS_ST_ROLE 14
`define GARS_ST_LOC_OK 13
`define GARS_ST_REM_OK 12
`define GARS_ST_LP_FD 11
`define GARS_ST_LP_HD 10
`define GARS_TEST_NORMAL 3'h0
`define GARS_CODE_NULL 11'h001
`define GARS_CTRL_RESET 16'h0300
`define GARS_IDLE_W 8
`endif

/* File: hw/gars_pkg.sv */
package gars_pkg;
  typedef logic [15:0] gars_word_t;
  typedef logic [4:0] gars_addr_t;
  typedef logic [2:0] gars_test_mode_t;
  typedef logic [10:0] gars_code_t;
  typedef enum logic {GARS_LINK_DOWN, GARS_LINK_SEEN} gars_link_t;
endpackage : gars_pkg

/* File: hw/gars_sat_cnt.sv */
`timescale 1ns/1ps
`default_nettype none
module gars_sat_cnt #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_inc,
  input wire logic i_clr,
  output logic [W-1:0] o_count
);
  localparam logic [W-1:0] MAX = '1;
  localparam logic [W-1:0] ONE = W'(1);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_count <= '0;
    end else if (i_ce) begin
      if (i_clr) begin
        // an error in the clearing cycle counts into the fresh value
        o_count <= i_inc ? ONE : '0;
      end else if (i_inc && o_count != MAX) begin
        o_count <= o_count + ONE;
      end
    end
  end

  sat_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && !i_clr && o_count == MAX) |=> o_count == MAX)
    else $error("idle counter left saturation");

  cnt_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && i_clr) |=> o_count == W'($past(i_inc)))
    else $error("idle counter not cleared by read");
endmodule : gars_sat_cnt
`default_nettype wire

/* File: verification/gars_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module gars_partner (
  input wire logic i_clk,
  output logic o_page_valid,
  output gars_pkg::gars_word_t o_page_word,
  output logic o_idle_err,
  output logic o_loc_ok,
  output logic o_rem_ok,
  output logic o_fd,
  output logic o_hd
);
  import gars_pkg::*;
  initial begin
    o_page_valid = 1'b0;
    o_page_word = 16'h0000;
    o_idle_err = 1'b0;
    {o_loc_ok, o_rem_ok, o_fd, o_hd} = 4'h0;
  end
  // one beat; the word line then shows the inverse so stale data never passes
  task automatic send_page(input gars_word_t w);
    @(posedge i_clk);
    o_page_valid <= 1'b1;
    o_page_word <= w;
    @(posedge i_clk);
    o_page_valid <= 1'b0;
    o_page_word <= ~w;
  endtask : send_page
  // n idle errors, one per cycle
  task automatic idle_burst(input int n);
    @(posedge i_clk);
    o_idle_err <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_idle_err <= 1'b0;
  endtask : idle_burst
  task automatic set_status(input logic [3:0] s);
    @(posedge i_clk);
    {o_loc_ok, o_rem_ok, o_fd, o_hd} <= s;
  endtask : set_status
endmodule : gars_partner
`default_nettype wire

/* File: verification/gars_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module gars_tb_top;
  import gars_pkg::*;
  typedef struct {logic w; gars_addr_t a; gars_word_t d;} gars_row_t;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic fault = 1'b0, auto_m = 1'b0, link = 1'b0;
  gars_addr_t addr = 5'h00;
  gars_word_t wdata = 16'h0000, rdata, pword;
  logic rvalid, hit, pvalid, idle, lok, rok, pfd, phd;
  gars_test_mode_t tmode;
  logic tact, men, mmas, role, multi, afd, ahd, acten, ctstart;
  int n_mismatch = 0, num_checks = 0;
  gars_row_t rows [11] = '{
    '{1'b0, 5'h08, 16'h2001}, '{1'b0, 5'h09, 16'h0300},
    '{1'b0, 5'h0a, 16'h0000}, '{1'b1, 5'h09, 16'hffff},
    '{1'b0, 5'h09, 16'hff80}, '{1'b1, 5'h09, 16'h0000},
    '{1'b1, 5'h08, 16'hffff}, '{1'b0, 5'h08, 16'hb7ff},
    '{1'b1, 5'h0a, 16'hffff}, '{1'b0, 5'h0a, 16'h0000},
    '{1'b0, 5'h1f, 16'h0000}};

  always #4 clk = ~clk;

  gars_partner p (.i_clk(clk), .o_page_valid(pvalid), .o_page_word(pword),
    .o_idle_err(idle), .o_loc_ok(lok), .o_rem_ok(rok), .o_fd(pfd),
    .o_hd(phd));

  gars_top dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_CORE_CE(ce),
    .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .O_REG_HIT(hit),
    .I_PAGE_VALID(pvalid), .I_PAGE_WORD(pword), .I_MS_FAULT(fault),
    .I_MS_AUTO_MASTER(auto_m), .I_LOCAL_RX_OK(lok), .I_REMOTE_RX_OK(rok),
    .I_PARTNER_1G_FD(pfd), .I_PARTNER_1G_HD(phd), .I_IDLE_ERR(idle),
    .I_LINK_UP(link), .O_TEST_MODE(tmode), .O_TEST_ACTIVE(tact),
    .O_MS_MANUAL_EN(men), .O_MS_MANUAL_MASTER(mmas), .O_ROLE_MASTER(role),
    .O_ADV_MULTI_PORT(multi), .O_ADV_1G_FD(afd), .O_ADV_1G_HD(ahd),
    .O_AUTO_CT_EN(acten), .O_CABLE_TEST_START(ctstart));

  task automatic stop_test();
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic wr_reg(input gars_addr_t a, input gars_word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input gars_addr_t a, input gars_word_t e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
    `CHK("hit", (a inside {5'h08, 5'h09, 5'h0a}), hit)
  endtask : rd_reg

  // fault raised in the very cycle that reads the status register
  task automatic rd_fault(input logic f, input gars_word_t e);
    @(posedge clk);
    addr <= 5'h0a;
    rd <= 1'b1;
    fault <= f;
    @(posedge clk);
    rd <= 1'b0;
    fault <= 1'b0;
    #1;
    `CHK("rdata_old", e, rdata)
  endtask : rd_fault

  task automatic role_case(input gars_word_t c, input logic am, input logic e);
    @(posedge clk);
    auto_m <= am;
    wr_reg(5'h09, c);
    @(posedge clk);
    #1;
    `CHK("role", e, role)
  endtask : role_case

  // only the cycles after the drop are counted for start pulses
  task automatic link_drop(input int e);
    int c;
    c = 0;
    @(posedge clk);
    link <= 1'b1;
    repeat (3) @(posedge clk);
    link <= 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1;
      c += int'(ctstart === 1'b1);
    end
    `CHK("ct_pulses", e, c)
  endtask : link_drop

  task automatic chk_reset_outs();
    #1;
    `CHK("adv_fd", 1'b1, afd)
    `CHK("adv_hd", 1'b1, ahd)
    `CHK("tmode", 3'h0, tmode)
    `CHK("multi", 1'b0, multi)
  endtask : chk_reset_outs

  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk_reset_outs();
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      else rd_reg(rows[i].a, rows[i].d);
    end
    for (int m = 0; m < 8; m++) begin
      wr_reg(5'h09, {m[2:0], 13'h0000});
      @(posedge clk);
      #1;
      `CHK("tmode", m[2:0], tmode)
      `CHK("tact", (m != 0), tact)
    end
    wr_reg(5'h09, 16'h0400);
    @(posedge clk);
    #1;
    `CHK("multi", 1'b1, multi)
    `CHK("adv_fd", 1'b0, afd)
    role_case(16'h1800, 1'b0, 1'b1);
    `CHK("men", 1'b1, men)
    `CHK("mmas", 1'b1, mmas)
    role_case(16'h1000, 1'b1, 1'b0);
    role_case(16'h0800, 1'b1, 1'b1);
    role_case(16'h0800, 1'b0, 1'b0);
    role_case(16'h1800, 1'b0, 1'b1);
    p.set_status(4'hf);
    rd_reg(5'h0a, 16'h7c00);
    p.set_status(4'ha);
    rd_reg(5'h0a, 16'h6800);
    @(posedge clk);
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    rd_reg(5'h0a, 16'he800);
    rd_reg(5'h0a, 16'h6800);
    rd_fault(1'b1, 16'h6800);
    rd_reg(5'h0a, 16'he800);
    rd_reg(5'h0a, 16'h6800);
    p.idle_burst(3);
    rd_reg(5'h0a, 16'h6803);
    rd_reg(5'h0a, 16'h6800);
    p.idle_burst(300);
    rd_reg(5'h0a, 16'h68ff);
    p.send_page(16'h9a55);
    rd_reg(5'h08, 16'h9255);
    p.send_page(16'h4000);
    rd_reg(5'h08, 16'h4800);
    wr_reg(5'h09, 16'h0080);
    #1;
    `CHK("acten", 1'b1, acten)
    link_drop(1);
    wr_reg(5'h09, 16'h0000);
    link_drop(0);
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(5'h09, 16'he000);
    @(posedge clk);
    ce <= 1'b1;
    rd_reg(5'h09, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk_reset_outs();
    rd_reg(5'h09, 16'h0300);
    rd_reg(5'h08, 16'h2001);
    stop_test();
  end
endmodule : gars_tb_top
`default_nettype wire
